// ==== hdl/chadp_device.sv ====
// Register datapath of the adapter: status, control, address and byte counters
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module chadp_device
  import chadp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  chadp_if.device          hb,
  // Sequencer phase, timeslots and flags
  input  wire logic [2:0]  phase,
  input  wire logic        ts1,
  input  wire logic        ts2,
  input  wire logic        lockout_flag,
  input  wire logic        bypass_flag,
  input  wire logic        sync_flag,
  input  wire logic        transfer_request_pending,
  input  wire logic        memory_transfer,
  input  wire logic        maint_single_clock,
  input  wire logic        bus_init,
  // Status set and clear sources
  input  wire logic        host_bus_timeout,
  input  wire logic        status_set_parity,
  input  wire logic [15:0] status_set,
  input  wire logic        set_system_reset,
  input  wire logic        set_rejected_sel,
  input  wire logic        clk_rejected_sel,
  input  wire logic [3:0]  status_clear_cond,
  // Transfer strobes and load sources
  input  wire logic        in_strobe,
  input  wire logic        out_strobe,
  input  wire logic [7:0]  unit_address_reg,
  input  wire logic [15:0] unit_offset_reg,
  input  wire logic [15:0] transfer_data_reg,
  input  wire logic [7:0]  bus_out,
  input  wire logic [15:0] table_index,
  input  wire logic [7:0]  unit_command_reg,
  // Side outputs
  output logic             data_end_flag,
  output logic             unit_transfer_flag,
  output logic             status_clear_n
);
  typedef struct packed {
    logic [15:0] ds;
    logic [15:0] cs;
    logic [15:0] ba;
    logic [15:0] bc;
    logic [7:0]  sb;
    logic        dend;
    logic        xfer;
    chadp_clr_t  clr;
    logic [1:0]  clr_cnt;
    logic        ba_inc;
  } chadp_state_t;

  chadp_state_t q;
  chadp_state_t next_q;
  logic         clr_req;
  logic         dev_reset;
  logic         strobe;
  logic         clr_active;
  logic         wr_ctrl;
  logic         wr_statb;
  logic         wr_baddr;
  logic         wr_bcnt;
  logic         wr_start;
  logic         dend_event;
  logic [15:0]  cs_load;

  assign dev_reset = rst;
  assign strobe    = in_strobe | out_strobe;
  assign clr_req   = |status_clear_cond;
  assign clr_active = (q.clr == CHADP_PULSE);
  assign dend_event = strobe && (q.bc == CHADP_MINUS_ONE);

  // Host write decodes; lockout blocks all but the start bit
  assign wr_ctrl  = hb.wr_stb && hb.wr_high && (hb.wr_addr == CHADP_ADR_CTRL) && !lockout_flag;
  assign wr_statb = hb.wr_stb && hb.wr_low && (hb.wr_addr == CHADP_ADR_STATB) && !lockout_flag;
  assign wr_baddr = hb.wr_stb && hb.wr_high && (hb.wr_addr == CHADP_ADR_BADDR) && !lockout_flag;
  assign wr_bcnt  = hb.wr_stb && hb.wr_high && (hb.wr_addr == CHADP_ADR_BCNT) && !lockout_flag;
  assign wr_start = hb.wr_stb && hb.wr_high && (hb.wr_addr == CHADP_ADR_CTRL) && hb.host_data_bus[CHADP_CS_START];

  // Per-bit control load enables; single-clock mode keeps only free-running bits
  for (genvar g = 0; g < 16; g++) begin : g_cs_load
    assign cs_load[g] = wr_ctrl && (!maint_single_clock || CHADP_CS_FREE[g]);
  end

  // Clear pulse length must fit its two-bit counter
  if (CHADP_CLR_CYC < 1 || CHADP_CLR_CYC > 4) begin : g_bad_clr
    $error("clear pulse length out of range");
  end

  always_comb begin
    next_q = q;
    // Set-only gating; a set in a clear cycle wins over the clear
    next_q.ds = (clr_active ? (q.ds & CHADP_DS_KEEP) : q.ds) | status_set;
    if (phase == CHADP_PH3 && ts1 && !bypass_flag && status_set_parity) begin
      next_q.ds[CHADP_B_PARITY] = 1'b1;
    end
    if (host_bus_timeout) begin
      next_q.ds[CHADP_B_NXM] = 1'b1;
    end
    if (set_system_reset) begin
      next_q.ds[CHADP_B_SYSTEM_RESET_FLAG] = 1'b1;
    end
    if (clk_rejected_sel) begin
      next_q.ds[CHADP_B_REJ] = 1'b0;
    end
    if (set_rejected_sel) begin
      next_q.ds[CHADP_B_REJ] = 1'b1;
    end

    // One clear pulse per request
    unique case (q.clr)
      CHADP_IDLE: begin
        if (clr_req) begin
          next_q.clr     = CHADP_PULSE;
          next_q.clr_cnt = 2'(CHADP_CLR_CYC - 1);
        end
      end
      CHADP_PULSE: begin
        if (q.clr_cnt == 2'h0) begin
          next_q.clr = CHADP_IDLE;
        end else begin
          next_q.clr_cnt = q.clr_cnt - 2'h1;
        end
      end
      default: next_q.clr = CHADP_IDLE;
    endcase

    // Control status load from bus
    next_q.cs = (q.cs & ~cs_load) | (hb.host_data_bus & cs_load);
    if (phase == CHADP_PH7 && ts1) begin
      next_q.cs = q.cs & ~CHADP_CS_FUNCTION_FIELD;
    end
    if (dev_reset || bus_init) begin
      next_q.cs = (q.cs & (16'h0001 << CHADP_CS_BUSY));
    end

    // Address counter: every load followed by +1
    next_q.ba_inc = 1'b0;
    if (q.ba_inc) begin
      next_q.ba = q.ba + CHADP_ONE;
    end
    if (wr_baddr) begin
      next_q.ba     = {hb.host_data_bus[15:1], 1'b0};
      next_q.ba_inc = 1'b1;
    end else if (phase == CHADP_PH1 && ts1) begin
      next_q.ba     = 16'({unit_address_reg, 1'b0}) + unit_offset_reg;
      next_q.ba[0]  = 1'b0;
      next_q.ba_inc = 1'b1;
    end else if (phase == CHADP_PH2 && ts1) begin
      next_q.ba     = {transfer_data_reg[15:8], bus_out[7:1], 1'b0};
      next_q.ba_inc = 1'b1;
    end else if (phase == CHADP_PH4 && ts1) begin
      next_q.ba     = {table_index[14:0], 1'b0};
      next_q.ba_inc = 1'b1;
    end else if (phase == CHADP_PH5 && ts1 && sync_flag && !transfer_request_pending) begin
      next_q.ba = q.ba + CHADP_TWO;
    end else if (out_strobe && !q.ba_inc) begin
      next_q.ba = q.ba + CHADP_ONE;
    end

    // Byte counter; the final strobe sets the data end status bit once
    if (wr_bcnt) begin
      next_q.bc = hb.host_data_bus;
    end else if (strobe) begin
      next_q.bc = q.bc + CHADP_ONE;
      if (dend_event) begin
        next_q.dend = 1'b1;
        next_q.xfer = 1'b0;
        next_q.ds[CHADP_B_DEND] = 1'b1;
      end
    end
    if (wr_start) begin
      next_q.xfer = 1'b1;
      next_q.dend = 1'b0;
    end

    // Status byte
    if (wr_statb) begin
      next_q.sb = hb.host_data_bus[7:0];
    end else if (phase == CHADP_PH1 && ts2 && memory_transfer) begin
      next_q.sb = transfer_data_reg[7:0];
    end else if (phase == CHADP_PH2 && ts2) begin
      next_q.sb = unit_command_reg[0] ? transfer_data_reg[15:8] : transfer_data_reg[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign hb.device_status       = q.ds;
  assign hb.unit_control_status = q.cs;
  assign hb.bus_address         = q.ba;
  assign hb.byte_counter        = q.bc;
  assign hb.unit_status_byte    = q.sb;
  assign hb.end_of_data         = q.dend;
  assign data_end_flag          = q.dend;
  assign unit_transfer_flag     = q.xfer;
  assign status_clear_n         = !clr_active;
endmodule

// ==== hdl/chadp_pkg.sv ====
// Constants and types shared by both ends of the channel adapter register datapath
// Operation
// - Device status bits are set-only from gating
// - Status clear spares disconnect, resets, rejected selection
// - Status clear: four ORed causes, one pulse
// - Reset and reject bits direct-set; reject clocked zero (here only the system reset flag has a direct set, none for selective reset)
// - Bit 14 flags nonexistent memory from timeout
// - Parity error sets phase 3 TS1, bypass clear
// - Control status bits loadable from data bus
// - Control load: address 04, high byte, unlocked
// - Busy cleared only by host write or reset; function cleared phase 7
// - Control clear on device reset or init
// - Single-clock mode loads only function, start
// - Address counter loads bit0 zero, then +1
// - Phase 5 TS1 sync, no request: +2
// - Address 10 high write loads bits 15:01
// - Phase 1 TS1 loads unit address plus offset
// - Phase 2 TS1 loads pointer and command
// - Phase 4 loads table index; output increments
// - Byte counter negative count, counts per strobe
// - Minus one on strobe sets data end
// - Address 06 low write loads status byte
// - Phase 1 TS2 granted loads transfer low byte
// - Phase 2 TS2 picks byte by command bit0
// - Odd commands out of memory, even into
package chadp_pkg;
  localparam int          CHADP_CLK_NS        = 20;
  localparam int          CHADP_CLR_PULSE_NS  = 30;
  localparam int          CHADP_CLR_CYC       = (CHADP_CLR_PULSE_NS + CHADP_CLK_NS - 1) / CHADP_CLK_NS;
  localparam logic [4:0]  CHADP_ADR_CTRL      = 5'h04;
  localparam logic [4:0]  CHADP_ADR_STATB     = 5'h06;
  localparam logic [4:0]  CHADP_ADR_BADDR     = 5'h10;
  localparam logic [4:0]  CHADP_ADR_BCNT      = 5'h12;
  localparam int          CHADP_B_PARITY      = 15;
  localparam int          CHADP_B_NXM         = 14;
  localparam int          CHADP_B_SELECTIVE_RESET_FLAG      = 13;
  localparam int          CHADP_B_SYSTEM_RESET_FLAG      = 12;
  localparam int          CHADP_B_DISC        = 11;
  localparam int          CHADP_B_DEND        = 4;
  localparam int          CHADP_B_REJ         = 3;
  localparam logic [15:0] CHADP_DS_KEEP       = 16'h3808;
  localparam int          CHADP_CS_BUSY       = 15;
  localparam int          CHADP_CS_START      = 0;
  localparam logic [15:0] CHADP_CS_FREE       = 16'h0007;
  localparam logic [15:0] CHADP_CS_FUNCTION_FIELD       = 16'h0006;
  localparam logic [15:0] CHADP_MINUS_ONE     = 16'hffff;
  localparam logic [15:0] CHADP_ONE           = 16'h0001;
  localparam logic [15:0] CHADP_TWO           = 16'h0002;
  localparam logic [2:0]  CHADP_PH1 = 3'h1, CHADP_PH2 = 3'h2, CHADP_PH3 = 3'h3;
  localparam logic [2:0]  CHADP_PH4 = 3'h4, CHADP_PH5 = 3'h5, CHADP_PH7 = 3'h7;
  typedef enum logic [1:0] {CHADP_IDLE = 2'b00, CHADP_PULSE = 2'b01} chadp_clr_t;
endpackage

// ==== hdl/chadp_if.sv ====
// Interface joining the host side to the register datapath
`timescale 1ns/1ps
interface chadp_if;
  logic        wr_stb;
  logic        wr_high;
  logic        wr_low;
  logic [4:0]  wr_addr;
  logic [15:0] host_data_bus;
  logic [15:0] device_status;
  logic [15:0] unit_control_status;
  logic [15:0] bus_address;
  logic [15:0] byte_counter;
  logic [7:0]  unit_status_byte;
  logic        end_of_data;
  modport device (input wr_stb, wr_high, wr_low, wr_addr, host_data_bus,
                  output device_status, unit_control_status, bus_address, byte_counter,
                  unit_status_byte, end_of_data);
  modport host (output wr_stb, wr_high, wr_low, wr_addr, host_data_bus,
                input device_status, unit_control_status, bus_address, byte_counter,
                unit_status_byte, end_of_data);
endinterface

// ==== hdl/chadp_host.sv ====
// Host end: turns AXI4-Lite register accesses into bus writes and reads
`timescale 1ns/1ps
module chadp_host
  import chadp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  chadp_if.host            hb,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw;
    logic        w_ok;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic        rv;
    logic [31:0] rd;
    logic        stb;
  } chadp_host_t;

  chadp_host_t q;
  chadp_host_t next_q;
  logic [4:0]  ridx;

  assign ridx = 5'(s_araddr[7:2]);

  always_comb begin
    next_q     = q;
    next_q.stb = 1'b0;
    if (s_awvalid && !q.aw_ok) begin
      next_q.aw_ok = 1'b1;
      next_q.aw    = s_awaddr;
    end
    if (s_wvalid && !q.w_ok) begin
      next_q.w_ok = 1'b1;
      next_q.wd   = s_wdata;
      next_q.ws   = s_wstrb;
    end
    if (q.aw_ok && q.w_ok && !q.bv) begin
      next_q.stb   = 1'b1;
      next_q.bv    = 1'b1;
      next_q.aw_ok = 1'b0;
      next_q.w_ok  = 1'b0;
    end
    if (q.bv && s_bready) begin
      next_q.bv = 1'b0;
    end
    if (s_arvalid && !q.rv) begin
      next_q.rv = 1'b1;
      unique case (ridx)
        5'h00:   next_q.rd = {16'h0000, hb.device_status};
        5'h01:   next_q.rd = {16'h0000, hb.unit_control_status};
        5'h02:   next_q.rd = {16'h0000, hb.bus_address};
        5'h03:   next_q.rd = {16'h0000, hb.byte_counter};
        5'h04:   next_q.rd = {24'h000000, hb.unit_status_byte};
        5'h05:   next_q.rd = {31'h00000000, hb.end_of_data};
        default: next_q.rd = 32'h00000000;
      endcase
    end else if (q.rv && s_rready) begin
      next_q.rv = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign s_awready        = !q.aw_ok;
  assign s_wready         = !q.w_ok;
  assign s_bvalid         = q.bv;
  assign s_bresp          = 2'b00;
  assign s_arready        = !q.rv;
  assign s_rvalid         = q.rv;
  assign s_rdata          = q.rd;
  assign s_rresp          = 2'b00;
  assign hb.wr_stb        = q.stb;
  assign hb.wr_addr       = 5'(q.aw[7:2]);
  assign hb.wr_high       = q.ws[1];
  assign hb.wr_low        = q.ws[0];
  assign hb.host_data_bus = q.wd[15:0];
endmodule

// ==== test/chadp_properties.sv ====
// Interface checker for the register datapath
`timescale 1ns/1ps
module chadp_properties
  import chadp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wr_stb,
  input wire logic        wr_high,
  input wire logic        wr_low,
  input wire logic [4:0]  wr_addr,
  input wire logic [15:0] host_data_bus,
  input wire logic [15:0] device_status,
  input wire logic [15:0] unit_control_status,
  input wire logic [15:0] bus_address,
  input wire logic [15:0] byte_counter,
  input wire logic [7:0]  unit_status_byte
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ba_load;
    wr_stb && wr_high && wr_addr == CHADP_ADR_BADDR |=>
      bus_address == {$past(host_data_bus[15:1]), 1'b0} ##1 bus_address == $past(bus_address) + CHADP_ONE;
  endproperty
  a_ba_load: assert property (p_ba_load) else $error("bus address load wrong");
  property p_cs_load;
    wr_stb && wr_high && wr_addr == CHADP_ADR_CTRL |=> unit_control_status[2:1] == $past(host_data_bus[2:1]);
  endproperty
  a_cs_load: assert property (p_cs_load) else $error("function load wrong");
  property p_sb_load;
    wr_stb && wr_low && wr_addr == CHADP_ADR_STATB |=> unit_status_byte == $past(host_data_bus[7:0]);
  endproperty
  a_sb_load: assert property (p_sb_load) else $error("status byte load wrong");
  property p_keep;
    (($past(device_status) & ~device_status) & 16'h3800) == 16'h0;
  endproperty
  a_keep: assert property (p_keep) else $error("kept status bit fell");
  property p_clr;
    (|($past(device_status) & ~device_status & 16'hc7f7)) |-> (device_status & 16'hc7f7) == 16'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("status bit fell alone");
  property p_bc;
    !$stable(byte_counter) && !$past(wr_stb) |-> byte_counter == $past(byte_counter) + CHADP_ONE;
  endproperty
  a_bc: assert property (p_bc) else $error("byte count step wrong");
  property p_dend;
    $past(byte_counter) == CHADP_MINUS_ONE && byte_counter == 16'h0 && !$past(wr_stb) |=>
      device_status[CHADP_B_DEND];
  endproperty
  a_dend: assert property (p_dend) else $error("data end not set");
  property p_rst;
    $fell(rst) |-> bus_address == 16'h0 && byte_counter == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left counters");
endmodule

// ==== test/tb_top.sv ====
// Bench joining host end and datapath
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module tb_top;
  import chadp_pkg::*;
  logic        clk_sys, rst, ts1, ts2, lockout_flag, bypass_flag, sync_flag, transfer_request_pending;
  logic        memory_transfer, maint_single_clock, bus_init, host_bus_timeout, status_set_parity;
  logic        set_system_reset, set_rejected_sel, clk_rejected_sel, in_strobe, out_strobe, data_end_flag;
  logic        unit_transfer_flag, status_clear_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [2:0]  phase;
  logic [3:0]  status_clear_cond, s_wstrb;
  logic [7:0]  unit_address_reg, bus_out, unit_command_reg, s_awaddr, s_araddr;
  logic [15:0] status_set, unit_offset_reg, transfer_data_reg, table_index, v, d, e;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0]  s_bresp, s_rresp;
  int          fail_count, n_checks, cycles, seed;
  chadp_if hbus ();
  chadp_device chadp_device_i (.clk_sys, .rst, .hb(hbus), .phase, .ts1, .ts2, .lockout_flag, .bypass_flag,
    .sync_flag, .transfer_request_pending, .memory_transfer, .maint_single_clock, .bus_init, .host_bus_timeout,
    .status_set_parity, .status_set, .set_system_reset, .set_rejected_sel, .clk_rejected_sel, .status_clear_cond,
    .in_strobe, .out_strobe, .unit_address_reg, .unit_offset_reg, .transfer_data_reg, .bus_out, .table_index,
    .unit_command_reg, .data_end_flag, .unit_transfer_flag, .status_clear_n);
  chadp_host chadp_host_i (.clk_sys, .rst, .hb(hbus), .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready);
  chadp_properties chadp_properties_i (.clk_sys, .rst, .wr_stb(hbus.wr_stb), .wr_high(hbus.wr_high),
    .wr_low(hbus.wr_low), .wr_addr(hbus.wr_addr), .host_data_bus(hbus.host_data_bus),
    .device_status(hbus.device_status), .unit_control_status(hbus.unit_control_status),
    .bus_address(hbus.bus_address), .byte_counter(hbus.byte_counter), .unit_status_byte(hbus.unit_status_byte));
  function automatic logic [15:0] ba_exp(input logic [15:0] x);
    return {x[15:1], 1'b0} + CHADP_ONE;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    logic ta, tw;
    s_awaddr <= a;
    s_wdata <= {16'h0, x};
    s_wstrb <= 4'h3;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ta = s_awready;
      tw = s_wready;
      @(posedge clk_sys);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end while (s_awvalid || s_wvalid);
    do begin
      @(negedge clk_sys);
      ta = s_bvalid;
      @(posedge clk_sys);
    end while (!ta);
    s_bready <= 1'b0;
  endtask
  task automatic chk(input int i, input logic [15:0] x, input logic [15:0] m, input string n);
    logic t;
    s_araddr <= 8'(i * 4);
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      t = s_arready;
      @(posedge clk_sys);
    end while (!t);
    s_arvalid <= 1'b0;
    do begin
      @(negedge clk_sys);
      t = s_rvalid;
      v = s_rdata[15:0];
      @(posedge clk_sys);
    end while (!t);
    s_rready <= 1'b0;
    `CHK(n, x & m, v & m)
  endtask
  task automatic ph_ba(input logic [2:0] p, input logic [15:0] x, input string n);
    {phase, ts1} <= {p, 1'b1};
    @(posedge clk_sys);
    {phase, ts1} <= '0;
    @(posedge clk_sys);
    chk(2, x, 16'hffff, n);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {ts1, ts2, lockout_flag, bypass_flag, sync_flag, transfer_request_pending, memory_transfer, maint_single_clock,
     bus_init, host_bus_timeout, status_set_parity, set_system_reset, set_rejected_sel, clk_rejected_sel,
     in_strobe, out_strobe, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, phase, status_clear_cond} = '0;
    {s_wstrb, unit_address_reg, bus_out, unit_command_reg, s_awaddr, s_araddr, status_set} = '0;
    {unit_offset_reg, transfer_data_reg, table_index, s_wdata} = '0;
    seed = 32'h3b6f59e9;
    rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int k = 0; k < 6; k++) begin
      d = (k == 0) ? 16'hffff : 16'($random(seed));
      maint_single_clock <= d[3];
      wr(8'h40, d);
      // Let the post-load increment land first
      @(posedge clk_sys);
      chk(2, ba_exp(d), 16'hffff, "bus_address");
      wr(8'h48, d);
      chk(3, d, 16'hffff, "byte_counter");
      wr(8'h18, d);
      chk(4, d, 16'h00ff, "unit_status_byte");
      wr(8'h10, d);
      chk(1, d, CHADP_CS_FUNCTION_FIELD, "function_field");
    end
    maint_single_clock <= 1'b0;
    lockout_flag <= 1'b1;
    wr(8'h48, ~d);
    lockout_flag <= 1'b0;
    chk(3, d, 16'hffff, "locked byte_counter");
    $display("done: host loads");
    wr(8'h48, 16'hfffe);
    in_strobe <= 1'b1;
    @(posedge clk_sys);
    in_strobe <= 1'b0;
    chk(3, CHADP_MINUS_ONE, 16'hffff, "byte_counter");
    out_strobe <= 1'b1;
    @(posedge clk_sys);
    out_strobe <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(0, 16'h0010, 16'h0010, "data_end_flag");
    chk(5, 16'h0001, 16'h0001, "end_of_data");
    `CHK("data_end_flag", 1'b1, data_end_flag)
    `CHK("unit_transfer_flag", 1'b0, unit_transfer_flag)
    $display("done: byte count");
    for (int b = 1; b >= 0; b--) begin
      {phase, ts1, status_set_parity, bypass_flag} <= {CHADP_PH3, 2'b11, 1'(b)};
      @(posedge clk_sys);
      {phase, ts1, status_set_parity} <= '0;
      chk(0, {~1'(b), 15'h0}, 16'h8000, "parity_error_flag");
    end
    e = 16'h8010;
    for (int j = 0; j < 4; j++) begin
      d = 16'($random(seed)) & 16'hc7e7;
      {status_set, set_system_reset, set_rejected_sel, host_bus_timeout} <= {d, 3'b111};
      @(posedge clk_sys);
      {status_set, set_system_reset, set_rejected_sel, host_bus_timeout} <= '0;
      e = e | d | 16'h5008;
      chk(0, e, 16'hffff, "device_status");
      status_clear_cond <= 4'h1 << j;
      @(posedge clk_sys);
      status_clear_cond <= 4'h0;
      for (int c = 0; c < 3; c++) begin
        @(negedge clk_sys);
        `CHK("status_clear_n", c == 2, status_clear_n)
      end
      @(posedge clk_sys);
      e = e & CHADP_DS_KEEP;
      chk(0, e, 16'hffff, "cleared device_status");
    end
    clk_rejected_sel <= 1'b1;
    @(posedge clk_sys);
    clk_rejected_sel <= 1'b0;
    chk(0, 16'h0, 16'h0008, "rejected_selection_flag");
    $display("done: device status");
    d = 16'($random(seed));
    transfer_data_reg <= d;
    {phase, ts2, memory_transfer} <= {CHADP_PH1, 2'b11};
    @(posedge clk_sys);
    {phase, ts2, memory_transfer} <= '0;
    chk(4, d, 16'h00ff, "granted status byte");
    for (int c = 1; c >= 0; c--) begin
      unit_command_reg <= 8'(c);
      {phase, ts2} <= {CHADP_PH2, 1'b1};
      @(posedge clk_sys);
      {phase, ts2} <= '0;
      chk(4, {8'h0, (c != 0) ? d[15:8] : d[7:0]}, 16'h00ff, "command byte pick");
    end
    d = 16'($random(seed));
    e = 16'($random(seed));
    {unit_address_reg, unit_offset_reg, bus_out, table_index} <= {d[7:0], e, d[15:8], e};
    ph_ba(CHADP_PH1, ba_exp(16'({d[7:0], 1'b0}) + e), "unit pointer address");
    ph_ba(CHADP_PH2, ba_exp({transfer_data_reg[15:8], d[15:8]}), "pointer and command");
    ph_ba(CHADP_PH4, ba_exp({e[14:0], 1'b0}), "table address");
    out_strobe <= 1'b1;
    @(posedge clk_sys);
    out_strobe <= 1'b0;
    chk(2, ba_exp({e[14:0], 1'b0}) + CHADP_ONE, 16'hffff, "output step");
    wr(8'h40, 16'h0100);
    {phase, ts1, sync_flag, transfer_request_pending} <= {CHADP_PH5, 3'b111};
    @(posedge clk_sys);
    transfer_request_pending <= 1'b0;
    repeat (3) @(posedge clk_sys);
    {phase, ts1, sync_flag} <= '0;
    chk(2, 16'h0107, 16'hffff, "bus_address step");
    wr(8'h10, 16'h8007);
    {phase, ts1} <= {CHADP_PH7, 1'b1};
    @(posedge clk_sys);
    {phase, ts1} <= '0;
    chk(1, 16'h8001, 16'h8007, "function clear");
    wr(8'h10, 16'h8006);
    bus_init <= 1'b1;
    @(posedge clk_sys);
    bus_init <= 1'b0;
    chk(1, 16'h8000, 16'h8007, "unit_control_status");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk(2, 16'h0, 16'hffff, "bus_address");
    chk(3, 16'h0, 16'hffff, "byte_counter");
    $display("done: phase loads and reset");
    complete_run();
  end
endmodule
